// ===== logic/fsp_ctrl.v
// flash self-programming sequencer: control register, gating, stall and flash strobes
// assumes cpu writes special function registers with a one-cycle strobe and
// that the flash array returns read data by the sixth cycle of a read
`include "fsp_map.vh"
module fsp_ctrl #(
  parameter integer PROG_CYCLES = `FSP_PROG_CYCLES
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // cpu register write port
  input wire sfr_wr,
  input wire [3:0] sfr_addr,
  input wire [3:0] sfr_wdata,
  // cpu state feeding the block
  input wire map_flag_zero,
  input wire map_flag_one,
  input wire [3:0] pointer_high_nibble,
  input wire [3:0] pointer_low_nibble,
  input wire [3:0] buffer_high_nibble,
  input wire [3:0] buffer_low_nibble,
  input wire [7:0] config_word,
  // serial programmer requests
  input wire serial_read_req,
  input wire serial_write_req,
  input wire serial_erase_req,
  input wire serial_chip_erase_req,
  // flash array read data
  input wire [7:0] flash_rdata,
  // cpu side results
  output reg [3:0] flash_prog_control,
  output reg cpu_stall,
  output reg watchdog_enable_set,
  output reg watchdog_clear,
  output reg buffer_load,
  output reg [7:0] buffer_rdata,
  // flash array controls
  output reg [9:0] flash_addr,
  output reg [7:0] flash_wdata,
  output reg flash_read,
  output reg flash_erase,
  output reg flash_write,
  output reg flash_chip_erase,
  // serial programmer grant
  output reg serial_grant
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_READ = 2'd1;
  localparam [1:0] ST_PROG = 2'd2;
  localparam [1:0] ST_DONE = 2'd3;
  localparam integer READ_LAST_I = `FSP_READ_CYCLES - 1;
  localparam [2:0] READ_LAST = READ_LAST_I[2:0];
  localparam [31:0] PROG_LAST = PROG_CYCLES - 1;

  // region base plus offset
  function [9:0] fsp_addr;
    input [1:0] region;
    input [5:0] offset;
    begin
      case (region)
        `FSP_REG_AREA0: fsp_addr = `FSP_BASE_AREA0 | {4'h0, offset}; // [R21] [R12]
        `FSP_REG_AREA1: fsp_addr = `FSP_BASE_AREA1 | {4'h0, offset}; // [R21] [R12]
        default: fsp_addr = `FSP_BASE_INFO | {7'h00, offset[2:0]}; // [R14]
      endcase
    end
  endfunction

  reg [1:0] state;
  reg [2:0] read_cnt;
  reg [31:0] prog_cnt;

  wire ctrl_wr = sfr_wr && (sfr_addr == `FSP_CTRL_ADDR);
  wire [1:0] wr_region = sfr_wdata[3:2];
  wire [1:0] wr_op = sfr_wdata[1:0];
  wire is_prog_op = (wr_op == `FSP_OP_ERASE) || (wr_op == `FSP_OP_WRITE); // [R13]
  wire permit = (wr_op == `FSP_OP_READ) ? config_word[`FSP_CFG_READ_BIT] :
                is_prog_op ? config_word[`FSP_CFG_PROG_BIT] : 1'b1; // [R17] [R18]
  wire map_ok = !map_flag_zero && map_flag_one;
  wire accept = ctrl_wr && (state == ST_IDLE) && map_ok && permit; // [R10] [R11]
  wire refused_info = is_prog_op && (wr_region == `FSP_REG_INFO); // [R09]
  wire runnable = (wr_op != `FSP_OP_NONE) && (wr_region != `FSP_REG_RSVD) && !refused_info;
  wire [5:0] offset = {pointer_high_nibble[1:0], pointer_low_nibble}; // [R06]
  wire serial_locked = config_word[`FSP_CFG_LOCK_BIT];

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      read_cnt <= 3'd0;
      prog_cnt <= 32'd0;
      flash_prog_control <= 4'h0;
      cpu_stall <= 1'b0;
      watchdog_enable_set <= 1'b0;
      watchdog_clear <= 1'b0;
      buffer_load <= 1'b0;
      buffer_rdata <= 8'h00;
      flash_addr <= 10'h000;
      flash_wdata <= 8'h00;
      flash_read <= 1'b0;
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_chip_erase <= 1'b0;
      serial_grant <= 1'b0;
    end
    else
    begin
      watchdog_enable_set <= ctrl_wr; // [R04]
      watchdog_clear <= 1'b0;
      buffer_load <= 1'b0;
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      // serial path: lock blocks all but chip erase; chip erase is the only info eraser
      serial_grant <= !serial_locked && (serial_read_req || serial_write_req ||
                      serial_erase_req); // [R16]
      flash_chip_erase <= serial_chip_erase_req && (state == ST_IDLE); // [R15] [R16]
      case (state)
        ST_IDLE:
        begin
          if (accept)
          begin
            flash_prog_control <= sfr_wdata;
            if (runnable)
            begin
              cpu_stall <= 1'b1; // [R01]
              flash_addr <= fsp_addr(wr_region, offset); // [R21]
              flash_wdata <= {buffer_high_nibble, buffer_low_nibble}; // [R07]
              if (wr_op == `FSP_OP_READ)
              begin
                state <= ST_READ;
                read_cnt <= 3'd0;
                flash_read <= 1'b1;
              end
              else
              begin
                state <= ST_PROG;
                prog_cnt <= 32'd0;
                watchdog_clear <= 1'b1; // [R05]
              end
            end
            else
            begin
              state <= ST_DONE; // [R22] [R09]
            end
          end
        end
        ST_READ:
        begin
          if (read_cnt == READ_LAST - 3'd1)
          begin
            flash_read <= 1'b0;
            buffer_rdata <= flash_rdata; // [R07]
            buffer_load <= 1'b1;
            cpu_stall <= 1'b0; // [R02] [R01]
            flash_prog_control <= 4'h0; // [R08]
            state <= ST_IDLE;
          end
          read_cnt <= read_cnt + 3'd1;
        end
        ST_PROG:
        begin
          // programming strobe begins one cycle after watchdog clear
          if (prog_cnt == 32'd0)
          begin
            if (flash_prog_control[1:0] == `FSP_OP_ERASE)
              flash_erase <= 1'b1;
            else
              flash_write <= 1'b1;
          end
          if (prog_cnt == PROG_LAST - 32'd1)
          begin
            cpu_stall <= 1'b0; // [R03] [R19]
            flash_prog_control <= 4'h0; // [R08]
            state <= ST_IDLE;
          end
          prog_cnt <= prog_cnt + 32'd1;
        end
        ST_DONE:
        begin
          flash_prog_control <= 4'h0; // [R22] [R08]
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // fsp_ctrl

// ===== logic/fsp_map.vh
// constants for the flash self-programming controller
// assumes one system clock at 100 MHz and an external flash array port
// Functional notes
// R01: cpu stalled during operation, resumes after the control write instruction
// R02: byte read completes in six system clocks, then cpu resumes
// R03: byte erase or write stalls cpu for about two milliseconds
// R04: any write attempt to control register forces watchdog run enable high
// R05: erase or write clears watchdog counter before programming starts
// R06: byte offset is low six bits of pointer high and low nibbles
// R07: two buffer nibbles supply write data and receive read data
// R08: control register returns to zero when operation finishes
// R09: erase and write to information region are refused
// R10: control write needs map flag zero clear, one set, permission bit set
// R11: blocked control write acts as no-operation
// R12: region codes 00 area zero, 01 area one, 10 information, 11 reserved
// R13: operation codes 00 none, 01 read, 10 erase, 11 write
// R14: information byte zero holds the configuration word
// R15: only serial full chip erase may erase information region
// R16: config bit 0 locks serial programmer except full chip erase
// R17: config bit 1 permits self-programming reads
// R18: config bit 2 permits self-programming erase and write
// R19: programming interval is a count of system clock cycles
// R20: software moves system clock to 5 to 11 MHz around programming
// R21: flash address is region base plus six bit offset; code uses only offset bits 2:0 for the information region
// R22: reserved region or no operation gives no access and no stall
`ifndef FSP_MAP_VH
`define FSP_MAP_VH
`define FSP_CTRL_ADDR 4'h9
`define FSP_CFG_ADDR 10'h000
`define FSP_REG_AREA0 2'b00
`define FSP_REG_AREA1 2'b01
`define FSP_REG_INFO 2'b10
`define FSP_REG_RSVD 2'b11
`define FSP_OP_NONE 2'b00
`define FSP_OP_READ 2'b01
`define FSP_OP_ERASE 2'b10
`define FSP_OP_WRITE 2'b11
`define FSP_BASE_AREA0 10'h1c0
`define FSP_BASE_AREA1 10'h3c0
`define FSP_BASE_INFO 10'h000
`define FSP_CFG_LOCK_BIT 0
`define FSP_CFG_READ_BIT 1
`define FSP_CFG_PROG_BIT 2
`define FSP_IFF_MAP_FLAG_ZERO 10
`define FSP_IFF_MAP_FLAG_ONE 11
`define FSP_IFF_WATCHDOG_RUN_ENABLE 13
`define FSP_READ_CYCLES 6
`define FSP_CLK_MHZ 100
`define FSP_PROG_US 2000
`define FSP_PROG_CYCLES (`FSP_PROG_US * `FSP_CLK_MHZ)
`endif

// ===== tb/fsp_ctrl_props.sv
// port checker for the flash sequencer
// assumes it is bound onto fsp_ctrl with a shortened programming count
module fsp_ctrl_props (
  input wire logic clk_sys, resetn, sfr_wr, map_flag_zero, map_flag_one,
  input wire logic cpu_stall, buffer_load, watchdog_enable_set, watchdog_clear,
  input wire logic flash_read, flash_erase, flash_write,
  input wire logic [3:0] sfr_addr, sfr_wdata, pointer_high_nibble, pointer_low_nibble,
  input wire logic [3:0] buffer_high_nibble, buffer_low_nibble, flash_prog_control,
  input wire logic [7:0] config_word, flash_wdata,
  input wire logic [9:0] flash_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire ctl = sfr_wr && sfr_addr == 4'h9 && !cpu_stall;
  wire ok = ctl && !map_flag_zero && map_flag_one;
  wire rd = ok && sfr_wdata[1:0] == 2'b01 && config_word[1] && sfr_wdata[3:2] != 2'b11;
  wire pg = ok && sfr_wdata[1] && config_word[2] && !sfr_wdata[3];
  sequence read_walk;
    (cpu_stall && flash_read) [*5] ##1 (!cpu_stall && buffer_load);
  endsequence
  a_ctl_wd_enable: assert property (ctl |=> watchdog_enable_set)
    else $error("watchdog enable not forced");
  a_read_six_cycles: assert property (rd |=> read_walk)
    else $error("read walk wrong");
  a_read_addr: assert property (rd && sfr_wdata[3:2] == 2'b00 |=> flash_addr ==
    (10'h1c0 | {4'h0, $past(pointer_high_nibble[1:0]), $past(pointer_low_nibble)}))
    else $error("read address wrong");
  a_prog_start: assert property (pg |=> cpu_stall && watchdog_clear ##1 (flash_erase || flash_write))
    else $error("programming start wrong");
  a_write_data: assert property (pg && sfr_wdata[0] |-> ##2 flash_write &&
    flash_wdata == $past({buffer_high_nibble, buffer_low_nibble}, 2))
    else $error("write byte wrong");
  a_blocked_nop: assert property (ctl && map_flag_zero |=> !cpu_stall && !flash_read
    && flash_prog_control == $past(flash_prog_control))
    else $error("blocked write acted");
  a_info_refused: assert property (ok && sfr_wdata[3:2] == 2'b10 && sfr_wdata[1] |=>
    !cpu_stall && !flash_erase && !flash_write ##1 flash_prog_control == 4'h0)
    else $error("info program not refused");
  a_ctrl_cleared: assert property ($fell(cpu_stall) |-> flash_prog_control == 4'h0)
    else $error("control not cleared");
  a_reserved_idle: assert property (ok && sfr_wdata[3:2] == 2'b11 |=> !cpu_stall && !flash_read)
    else $error("reserved region acted");
endmodule // fsp_ctrl_props
bind fsp_ctrl fsp_ctrl_props i_props (.*);

// ===== tb/fsp_flash_model.sv
// flash array stand-in: returns a byte derived from the address
// assumes the controller holds flash_read through the whole read
module fsp_flash_model (
  input wire logic clk_sys,
  input wire logic flash_read,
  input wire logic [9:0] flash_addr,
  output logic [7:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial flash_rdata = 8'h00;
  // outside a read the data toggles so a stale byte never matches
  always @(posedge clk_sys)
    flash_rdata <= flash_read ? flash_addr[7:0] ^ 8'ha5 : ~flash_rdata;
endmodule // fsp_flash_model

// ===== tb/testbench.sv
// self-checking bench for the flash sequencer
// assumes a 100 MHz clock and a shortened programming count
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // shortened interval stands for the slowed programming clock
  localparam int PROG = 20;
  logic clk_sys, resetn, sfr_wr, map_flag_zero, map_flag_one, serial_read_req;
  logic serial_write_req, serial_erase_req, serial_chip_erase_req, cpu_stall, buffer_load;
  logic watchdog_enable_set, watchdog_clear, flash_read, flash_erase, flash_write;
  logic flash_chip_erase, serial_grant;
  logic [3:0] sfr_addr, sfr_wdata, pointer_high_nibble, pointer_low_nibble;
  logic [3:0] buffer_high_nibble, buffer_low_nibble, flash_prog_control;
  logic [7:0] config_word, flash_rdata, buffer_rdata, flash_wdata;
  logic [9:0] flash_addr;
  int err_total = 0, samples_checked = 0, cyc = 0;
  fsp_ctrl #(.PROG_CYCLES(PROG)) i_dut (.*);
  fsp_flash_model i_flash (.*);
  task report_and_stop;
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge clk_sys);
    #1;
  endtask
  task ctl_write(input logic [3:0] v);
    sfr_wr = 1;
    sfr_addr = 4'h9;
    sfr_wdata = v;
    step;
    sfr_wr = 0;
  endtask
  task t_read(input logic [1:0] rg, input logic [7:0] exp, input logic [9:0] ad);
    int n;
    n = 1;
    ctl_write({rg, 2'b01});
    chk(flash_addr, ad);
    chk(flash_read, 1);
    while (!buffer_load && n < 50)
    begin
      step;
      n++;
    end
    chk(10'(n), 6);
    chk(buffer_rdata, exp);
    chk(flash_prog_control, 0);
  endtask
  task t_prog(input logic [1:0] op);
    int n;
    n = 1;
    ctl_write({2'b01, op});
    chk(watchdog_clear, 1);
    step;
    n = 2;
    chk({flash_erase, flash_write}, {~op[0], op[0]});
    while (cpu_stall && n < 99)
    begin
      step;
      n++;
    end
    chk(10'(n), PROG);
  endtask
  task t_refuse(input logic [3:0] v, input logic mz, input logic [7:0] cfg);
    map_flag_zero = mz;
    config_word = cfg;
    ctl_write(v);
    chk(watchdog_enable_set, 1);
    chk({flash_read, flash_erase, flash_write, cpu_stall}, 0);
    step;
    chk(flash_prog_control, 0);
    map_flag_zero = 0;
    config_word = 8'h06;
  endtask
  task t_serial(input logic lock, input logic [2:0] req);
    config_word = 8'h06 | lock;
    {serial_read_req, serial_write_req, serial_erase_req} = req;
    serial_chip_erase_req = 1;
    step;
    step;
    chk({serial_grant, flash_chip_erase}, {~lock, 1'b1});
    {serial_read_req, serial_write_req, serial_erase_req} = 0;
    serial_chip_erase_req = 0;
    config_word = 8'h06;
    step;
    step;
  endtask
  initial
  begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      report_and_stop;
    end
  end
  initial
  begin
    {resetn, sfr_wr, sfr_addr, sfr_wdata, map_flag_zero, map_flag_one} = 0;
    {serial_read_req, serial_write_req, serial_erase_req, serial_chip_erase_req} = 0;
    map_flag_one = 1;
    pointer_high_nibble = 4'hb;
    pointer_low_nibble = 4'h4;
    buffer_high_nibble = 4'h3;
    buffer_low_nibble = 4'hc;
    config_word = 8'h06;
    repeat (8) @(posedge clk_sys);
    #1 resetn = 1;
    t_read(2'b00, 8'h51, 10'h1f4);
    t_read(2'b01, 8'h51, 10'h3f4);
    t_read(2'b10, 8'ha1, 10'h004);
    t_prog(2'b10);
    t_prog(2'b11);
    t_refuse(4'h1, 1, 8'h06);
    t_refuse(4'h1, 0, 8'h04);
    t_refuse(4'h7, 0, 8'h02);
    t_refuse(4'hb, 0, 8'h06);
    t_refuse(4'hd, 0, 8'h06);
    t_refuse(4'h0, 0, 8'h06);
    t_serial(0, 3'b100);
    t_serial(1, 3'b111);
    t_serial(0, 3'b010);
    t_serial(0, 3'b001);
    report_and_stop;
  end
endmodule // testbench
